/* shared/wpsc_pkg.sv */
/*
  Constants, types and register map of the watchdog and power-save controller.
  Assumes a 200 MHz system clock and APB with 32-bit data and 12-bit addresses.
*/
package wpsc_pkg;

  localparam int PERIPH_N = 16;

  // Register byte addresses
  localparam logic [11:0] ADDR_RESET_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CLK_DIV = 12'h004;
  localparam logic [11:0] ADDR_MOD_DIS = 12'h008;
  localparam logic [11:0] ADDR_PWR_STAT = 12'h00C;

  // reset_control_register fields
  localparam int RC_IDLE_BIT = 2;
  localparam int RC_SLEEP_BIT = 3;
  localparam int RC_WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int RC_WATCHDOG_SOFT_ENABLE_BIT = 5;

  // clock_divisor_register fields
  localparam int CD_CPU_CLOCK_REDUCE_ENABLE_BIT = 11;
  localparam int CD_DOZE_LSB = 12;
  localparam int CD_DOZE_MSB = 14;
  localparam int CD_ROI_BIT = 15;

  // Power status register fields
  localparam int PS_STATE_LSB = 0;
  localparam int PS_STATE_MSB = 1;
  localparam int PS_WDT_EN_BIT = 2;
  localparam int PS_RST_PEND_BIT = 3;

  // Reset values
  localparam logic [2:0] DOZE_RESET = 3'h0;
  localparam logic [PERIPH_N-1:0] MOD_DIS_RESET = 16'h0000;

  // Timing: CPU restarts well inside the eight-cycle limit
  localparam int RESUME_MAX_CYC = 8;
  localparam logic [2:0] RESUME_DELAY_CYC = 3'h2;

  // Watchdog divider and window constants
  localparam logic [4:0] WDT_PRE_LO_LOG2 = 5'h05;
  localparam logic [4:0] WDT_PRE_HI_LOG2 = 5'h07;
  localparam logic [4:0] WDT_EIGHTH_LOG2 = 5'h03;
  localparam logic [22:0] WIN_OPEN_25 = 23'h000006;
  localparam logic [22:0] WIN_OPEN_375 = 23'h000005;
  localparam logic [22:0] WIN_OPEN_50 = 23'h000004;
  localparam logic [22:0] WIN_OPEN_75 = 23'h000002;

  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_IDLE = 2'b01,
    PM_SLEEP = 2'b10,
    PM_WAKE = 2'b11
  } wpsc_state_t;

  // watchdog_config_word layout; bit 5 and 15:10 unused
  typedef struct packed {
    logic [5:0] unused_hi;
    logic [1:0] window_size_select;
    logic watchdog_fuse_enable;
    logic window_disable;
    logic unused_5;
    logic watchdog_prescale_select;
    logic [3:0] watchdog_postscale_select;
  } wpsc_wdt_cfg_t;

  typedef struct packed {
    logic valid;
    logic idle;
  } wpsc_power_save_instruction_t;

  typedef struct packed {
    logic pending;
    logic [2:0] prio;
  } wpsc_irq_t;

endpackage

/* verilog/wpsc_wdt.sv */
/*
  Watchdog counter: prescaler then postscaler, stepped by rising edges of the
  low-power RC oscillator. Assumes that oscillator input is synchronous to i_mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module wpsc_wdt
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_low_power_rc_oscillator,
  input wire logic i_enable,
  input wire logic i_restart,
  input wire logic i_clear_insn,
  input wire wpsc_pkg::wpsc_wdt_cfg_t i_cfg,
  output logic o_timeout,
  output logic o_early_clear
);
  import wpsc_pkg::*;

  logic low_power_rc_oscillator_d_r;
  logic [6:0] pre_cnt_r;
  logic [14:0] post_cnt_r;
  logic tick;
  logic pre_last;
  logic post_last;
  logic [22:0] elapsed;
  logic [4:0] period_log2;
  logic [22:0] win_factor;
  logic win_open;
  logic expire;

  assign tick = i_low_power_rc_oscillator & ~low_power_rc_oscillator_d_r;
  assign pre_last = i_cfg.watchdog_prescale_select ? (pre_cnt_r == 7'h7F)
                                                   : (pre_cnt_r[4:0] == 5'h1F);
  assign post_last = post_cnt_r ==
    15'((16'h0001 << i_cfg.watchdog_postscale_select) - 16'h0001);
  assign elapsed = i_cfg.watchdog_prescale_select ? {1'b0, post_cnt_r, pre_cnt_r}
                                                  : {3'h0, post_cnt_r, pre_cnt_r[4:0]};
  assign period_log2 = (i_cfg.watchdog_prescale_select ? WDT_PRE_HI_LOG2 : WDT_PRE_LO_LOG2)
                       + {1'b0, i_cfg.watchdog_postscale_select};

  always_comb
  begin
    case (i_cfg.window_size_select)
      2'b11: win_factor = WIN_OPEN_25;
      2'b10: win_factor = WIN_OPEN_375;
      2'b01: win_factor = WIN_OPEN_50;
      default: win_factor = WIN_OPEN_75;
    endcase
  end

  // Window is the last fraction of the period, counted in eighths
  assign win_open = elapsed >= (win_factor << (period_log2 - WDT_EIGHTH_LOG2));
  assign expire = i_enable & tick & pre_last & post_last;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      low_power_rc_oscillator_d_r <= 1'b0;
    else
      low_power_rc_oscillator_d_r <= i_low_power_rc_oscillator;
  end

  // Counts only on oscillator edges, never on the system clock rate
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pre_cnt_r <= 7'h00;
      post_cnt_r <= 15'h0000;
    end
    else if (!i_enable || i_restart || i_clear_insn || expire)
    begin
      pre_cnt_r <= 7'h00;
      post_cnt_r <= 15'h0000;
    end
    else if (tick)
    begin
      if (pre_last)
      begin
        pre_cnt_r <= 7'h00;
        post_cnt_r <= post_cnt_r + 15'h0001;
      end
      else
        pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_timeout <= 1'b0;
      o_early_clear <= 1'b0;
    end
    else
    begin
      o_timeout <= expire;
      o_early_clear <= i_enable & i_clear_insn & ~i_cfg.window_disable & ~win_open;
    end
  end

endmodule
`default_nettype wire

/* verilog/wpsc_top.sv */
/*
  Watchdog and power-save controller: Idle/Sleep sequencing, wake-up, Doze
  CPU clock enable, module disable clock gates, APB register file.
  Assumes the core pulses instruction events for one cycle and that the reset
  logic answers o_wdt_reset by raising i_rst; status flags survive i_rst and
  are cleared only by i_por_rst or by a write to the reset control register.
*/
// Contract
// - Idle halts CPU; peripherals honour stop-in-idle
// - CPU resumes within eight cycles after exit
// - Interrupt, watchdog time-out or reset end Idle/Sleep
// - Low-priority interrupt resumes after power-save instruction
// - High-priority interrupt wakes into exception processing
// - Watchdog wake resumes and sets time-out flag
// - Any reset ends Idle/Sleep, restarts at vector
// - Timed interrupt disable never blocks Sleep wake
// - Doze enable slows CPU, peripherals full rate
// - Three-bit doze ratio field, 1:1 at reset
// - Recover-on-interrupt restores full CPU speed
// - Module disable bits gate clocks, reset enabled
// - Watchdog prescaler and postscaler run from RC oscillator
// - Awake watchdog time-out forces reset, sets flag
// - Power-save entry clears watchdog count
// - Watchdog reset waits for self-programming end; only time-out reset waits here, early-clear reset does not
// - Fuse enable bit forces watchdog permanently on
// - Soft enable bit, cleared by any reset
// - Early clear in windowed mode resets immediately
// - Window size codes select allowed fraction
// - Period is prescale times postscale times RC period
// - Postscaler codes give ratios 1 to 32768
// - Soft enable and clock switch clear count
// - Entry sets Idle or Sleep status flag
`timescale 1ns/10ps
`default_nettype none
module wpsc_top
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_por_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire wpsc_pkg::wpsc_power_save_instruction_t i_power_save_instruction,
  input wire wpsc_pkg::wpsc_irq_t i_irq,
  input wire logic [2:0] i_cpu_prio,
  input wire logic i_timed_irq_disable,
  input wire logic i_wdt_clear,
  input wire logic i_clk_switch_done,
  input wire logic i_self_prog_busy,
  input wire logic i_low_power_rc_oscillator_clk,
  input wire wpsc_pkg::wpsc_wdt_cfg_t i_wdt_cfg,
  input wire logic [wpsc_pkg::PERIPH_N-1:0] i_stop_in_idle,
  output logic o_cpu_clk_en,
  output logic o_sys_clk_en,
  output logic [wpsc_pkg::PERIPH_N-1:0] o_periph_clk_en,
  output logic o_in_idle,
  output logic o_in_sleep,
  output logic o_resume_next,
  output logic o_take_exception,
  output logic o_wdt_reset
);
  import wpsc_pkg::*;

  wpsc_state_t state_r;
  wpsc_state_t state_nxt;
  logic [2:0] wake_cnt_r;
  logic wake_exc_r;
  logic idle_flag_r;
  logic sleep_flag_r;
  logic watchdog_timeout_flag_flag_r;
  logic watchdog_soft_enable_r;
  logic watchdog_soft_enable_d_r;
  logic roi_r;
  logic [2:0] doze_r;
  logic cpu_clock_reduce_enable_r;
  logic [PERIPH_N-1:0] mod_dis_r;
  logic [6:0] doze_cnt_r;
  logic rst_pend_r;
  logic wdt_en;
  logic wdt_timeout;
  logic wdt_early;
  logic wdt_restart;
  logic enter_ps;
  logic asleep;
  logic wake_irq;
  logic acc_done;
  logic wr_en;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic [6:0] doze_last;
  logic roi_recover;

  assign wdt_en = i_wdt_cfg.watchdog_fuse_enable | watchdog_soft_enable_r;
  assign enter_ps = (state_r == PM_RUN) & i_power_save_instruction.valid;
  assign asleep = (state_r == PM_IDLE) | (state_r == PM_SLEEP);
  // Interrupt disable state is deliberately not looked at while asleep
  assign wake_irq = asleep & i_irq.pending;
  assign wdt_restart = enter_ps | i_clk_switch_done | (watchdog_soft_enable_r & ~watchdog_soft_enable_d_r);

  wpsc_wdt u_wdt
  (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_low_power_rc_oscillator(i_low_power_rc_oscillator_clk),
    .i_enable(wdt_en),
    .i_restart(wdt_restart),
    .i_clear_insn(i_wdt_clear & (state_r == PM_RUN)),
    .i_cfg(i_wdt_cfg),
    .o_timeout(wdt_timeout),
    .o_early_clear(wdt_early)
  );

  // APB: one wait state, so pready rises on the second access cycle
  assign acc_done = i_psel & i_penable & o_pready;
  assign wr_en = acc_done & i_pwrite & addr_hit;

  always_comb
  begin
    rd_mux = 32'h00000000;
    addr_hit = 1'b1;
    if (i_paddr == ADDR_RESET_CTRL)
    begin
      rd_mux[RC_IDLE_BIT] = idle_flag_r;
      rd_mux[RC_SLEEP_BIT] = sleep_flag_r;
      rd_mux[RC_WATCHDOG_TIMEOUT_FLAG_BIT] = watchdog_timeout_flag_flag_r;
      rd_mux[RC_WATCHDOG_SOFT_ENABLE_BIT] = watchdog_soft_enable_r;
    end
    else if (i_paddr == ADDR_CLK_DIV)
    begin
      rd_mux[CD_ROI_BIT] = roi_r;
      rd_mux[CD_DOZE_MSB:CD_DOZE_LSB] = doze_r;
      rd_mux[CD_CPU_CLOCK_REDUCE_ENABLE_BIT] = cpu_clock_reduce_enable_r;
    end
    else if (i_paddr == ADDR_MOD_DIS)
      rd_mux[PERIPH_N-1:0] = mod_dis_r;
    else if (i_paddr == ADDR_PWR_STAT)
    begin
      rd_mux[PS_STATE_MSB:PS_STATE_LSB] = state_r;
      rd_mux[PS_WDT_EN_BIT] = wdt_en;
      rd_mux[PS_RST_PEND_BIT] = rst_pend_r;
    end
    else
      addr_hit = 1'b0;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= i_psel & i_penable & ~o_pready;
      if (i_psel & i_penable & ~o_pready)
      begin
        o_prdata <= i_pwrite ? 32'h00000000 : rd_mux;
        o_pslverr <= ~addr_hit;
      end
      else
      begin
        o_prdata <= 32'h00000000;
        o_pslverr <= 1'b0;
      end
    end
  end

  // Status flags live on the power-on reset so a watchdog reset keeps them
  always_ff @(posedge i_mclk or posedge i_por_rst)
  begin
    if (i_por_rst)
    begin
      idle_flag_r <= 1'b0;
      sleep_flag_r <= 1'b0;
      watchdog_timeout_flag_flag_r <= 1'b0;
    end
    else
    begin
      // Hardware set wins over a software write in the same cycle
      if (enter_ps & i_power_save_instruction.idle)
        idle_flag_r <= 1'b1;
      else if (wr_en && i_paddr == ADDR_RESET_CTRL)
        idle_flag_r <= i_pwdata[RC_IDLE_BIT];
      if (enter_ps & ~i_power_save_instruction.idle)
        sleep_flag_r <= 1'b1;
      else if (wr_en && i_paddr == ADDR_RESET_CTRL)
        sleep_flag_r <= i_pwdata[RC_SLEEP_BIT];
      if (wdt_timeout)
        watchdog_timeout_flag_flag_r <= 1'b1;
      else if (wr_en && i_paddr == ADDR_RESET_CTRL)
        watchdog_timeout_flag_flag_r <= i_pwdata[RC_WATCHDOG_TIMEOUT_FLAG_BIT];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      watchdog_soft_enable_r <= 1'b0;
      watchdog_soft_enable_d_r <= 1'b0;
    end
    else
    begin
      watchdog_soft_enable_d_r <= watchdog_soft_enable_r;
      if (wr_en && i_paddr == ADDR_RESET_CTRL)
        watchdog_soft_enable_r <= i_pwdata[RC_WATCHDOG_SOFT_ENABLE_BIT];
    end
  end

  // Hardware recovery clears the doze enable, beating a software write
  assign roi_recover = (state_r == PM_RUN) & roi_r & cpu_clock_reduce_enable_r & i_irq.pending
                       & ~i_timed_irq_disable;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      roi_r <= 1'b0;
      doze_r <= DOZE_RESET;
      cpu_clock_reduce_enable_r <= 1'b0;
    end
    else
    begin
      if (wr_en && i_paddr == ADDR_CLK_DIV)
      begin
        roi_r <= i_pwdata[CD_ROI_BIT];
        doze_r <= i_pwdata[CD_DOZE_MSB:CD_DOZE_LSB];
      end
      if (roi_recover)
        cpu_clock_reduce_enable_r <= 1'b0;
      else if (wr_en && i_paddr == ADDR_CLK_DIV)
        cpu_clock_reduce_enable_r <= i_pwdata[CD_CPU_CLOCK_REDUCE_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      mod_dis_r <= MOD_DIS_RESET;
    else if (wr_en && i_paddr == ADDR_MOD_DIS)
      mod_dis_r <= i_pwdata[PERIPH_N-1:0];
  end

  // Power-save sequencer; reset returns it to run at the vector
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PM_RUN:
      begin
        if (i_power_save_instruction.valid)
          state_nxt = i_power_save_instruction.idle ? PM_IDLE : PM_SLEEP;
      end
      PM_IDLE, PM_SLEEP:
      begin
        if (wake_irq || wdt_timeout)
          state_nxt = PM_WAKE;
      end
      PM_WAKE:
      begin
        if (wake_cnt_r == 3'h0)
          state_nxt = PM_RUN;
      end
      default: state_nxt = PM_RUN;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      state_r <= PM_RUN;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wake_cnt_r <= 3'h0;
      wake_exc_r <= 1'b0;
    end
    else if (asleep && state_nxt == PM_WAKE)
    begin
      wake_cnt_r <= RESUME_DELAY_CYC - 3'h1;
      wake_exc_r <= wake_irq & (i_irq.prio > i_cpu_prio);
    end
    else if (state_r == PM_WAKE && wake_cnt_r != 3'h0)
      wake_cnt_r <= wake_cnt_r - 3'h1;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_resume_next <= 1'b0;
      o_take_exception <= 1'b0;
    end
    else
    begin
      o_resume_next <= (state_r == PM_WAKE) & (wake_cnt_r == 3'h0) & ~wake_exc_r;
      o_take_exception <= (state_r == PM_WAKE) & (wake_cnt_r == 3'h0) & wake_exc_r;
    end
  end

  // Watchdog reset request held until the reset logic answers
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rst_pend_r <= 1'b0;
      o_wdt_reset <= 1'b0;
    end
    else
    begin
      if (wdt_early)
        o_wdt_reset <= 1'b1;
      else if ((rst_pend_r || (wdt_timeout && !asleep)) && !i_self_prog_busy)
        o_wdt_reset <= 1'b1;
      if (wdt_timeout && !asleep && i_self_prog_busy)
        rst_pend_r <= 1'b1;
    end
  end

  // Doze: CPU clock enable one cycle in 2^ratio
  assign doze_last = 7'((8'h01 << doze_r) - 8'h01);

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      doze_cnt_r <= 7'h00;
      o_cpu_clk_en <= 1'b0;
    end
    else if (state_nxt != PM_RUN)
    begin
      doze_cnt_r <= 7'h00;
      o_cpu_clk_en <= 1'b0;
    end
    else if (cpu_clock_reduce_enable_r && !roi_recover)
    begin
      doze_cnt_r <= (doze_cnt_r >= doze_last) ? 7'h00 : doze_cnt_r + 7'h01;
      o_cpu_clk_en <= doze_cnt_r >= doze_last;
    end
    else
    begin
      doze_cnt_r <= 7'h00;
      o_cpu_clk_en <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sys_clk_en <= 1'b1;
      o_in_idle <= 1'b0;
      o_in_sleep <= 1'b0;
    end
    else
    begin
      o_sys_clk_en <= state_nxt != PM_SLEEP;
      o_in_idle <= state_nxt == PM_IDLE;
      o_in_sleep <= state_nxt == PM_SLEEP;
    end
  end

  // Peripheral clock gates run at full system rate even in Doze
  genvar gi;
  generate
    for (gi = 0; gi < PERIPH_N; gi = gi + 1)
    begin : g_periph
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
          o_periph_clk_en[gi] <= 1'b1;
        else
          o_periph_clk_en[gi] <= ~mod_dis_r[gi] & (state_nxt != PM_SLEEP)
            & ~((state_nxt == PM_IDLE) & i_stop_in_idle[gi]);
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* test/wpsc_partner.sv */
/*
  Far-side model: reset logic and low-power RC oscillator.
  Assumes the top answers a watchdog reset only through o_wdt_reset.
*/
`timescale 1ns/10ps
`default_nettype none
module wpsc_partner
(
  input wire logic i_mclk,
  input wire logic i_bench_rst,
  input wire logic i_wdt_rst,
  output logic o_rst,
  output logic o_low_power_rc_oscillator
);
  logic [1:0] div_r = 2'h0;
  logic [1:0] hold_r = 2'h0;
  // Synchronous RC stand-in, one rising edge every four cycles
  always_ff @(posedge i_mclk)
    div_r <= div_r + 2'h1;
  assign o_low_power_rc_oscillator = div_r[1];
  // Reset answer lasts a few cycles past the request
  always_ff @(posedge i_mclk)
    hold_r <= i_wdt_rst ? 2'h3 : hold_r - 2'(hold_r != 2'h0);
  assign o_rst = i_bench_rst | (hold_r != 2'h0);
endmodule
`default_nettype wire

/* test/wpsc_props.sv */
/*
  Port-level checker for the power-save and watchdog controller.
  Assumes single clock i_mclk; attached by the bind below.
*/
`timescale 1ns/10ps
`default_nettype none
module wpsc_props
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire wpsc_pkg::wpsc_power_save_instruction_t i_power_save_instruction,
  input wire wpsc_pkg::wpsc_irq_t i_irq,
  input wire logic [2:0] i_cpu_prio,
  input wire logic i_self_prog_busy,
  input wire logic [wpsc_pkg::PERIPH_N-1:0] i_stop_in_idle,
  input wire logic o_cpu_clk_en,
  input wire logic o_sys_clk_en,
  input wire logic [wpsc_pkg::PERIPH_N-1:0] o_periph_clk_en,
  input wire logic o_in_idle,
  input wire logic o_in_sleep,
  input wire logic o_resume_next,
  input wire logic o_take_exception,
  input wire logic o_wdt_reset
);
  import wpsc_pkg::*;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  sequence s_asleep_irq;
    (o_in_idle || o_in_sleep) && i_irq.pending;
  endsequence
  sequence s_woken;
    ##[1:8] (o_resume_next || o_take_exception);
  endsequence
  a_apb_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("ready late");
  a_rdata_quiet: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer");
  a_halt_cpu_off: assert property (o_in_idle || o_in_sleep |-> !o_cpu_clk_en)
    else $error("cpu clock in power save");
  a_idle_stop_bits: assert property (o_in_idle |-> !(o_periph_clk_en & i_stop_in_idle))
    else $error("stopped peripheral clocked");
  a_mode_entry: assert property (i_power_save_instruction.valid && !o_in_idle && !o_in_sleep |=>
    o_in_idle == $past(i_power_save_instruction.idle) && o_in_sleep != $past(i_power_save_instruction.idle))
    else $error("wrong mode entered");
  a_wake_bound: assert property (s_asleep_irq |-> s_woken)
    else $error("wake too slow");
  a_exc_prio: assert property (o_take_exception |-> i_irq.prio > i_cpu_prio)
    else $error("exception at low priority");
  a_resume_prio: assert property (o_resume_next && i_irq.pending |->
    i_irq.prio <= i_cpu_prio)
    else $error("resume at high priority");
  a_wake_cpu_on: assert property (o_resume_next || o_take_exception |-> o_cpu_clk_en)
    else $error("cpu clock off at resume");
  a_sleep_sys_off: assert property (o_in_sleep |-> !o_sys_clk_en)
    else $error("system clock in sleep");
  a_wdt_rst_hold: assert property (o_wdt_reset |=> o_wdt_reset)
    else $error("watchdog reset dropped");
  a_busy_defers: assert property ($rose(o_wdt_reset) |-> !$past(i_self_prog_busy))
    else $error("reset during flash cycle");
endmodule
bind wpsc_top wpsc_props chk_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready), .i_power_save_instruction(i_power_save_instruction),
  .i_irq(i_irq), .i_cpu_prio(i_cpu_prio), .i_self_prog_busy(i_self_prog_busy),
  .i_stop_in_idle(i_stop_in_idle), .o_cpu_clk_en(o_cpu_clk_en), .o_sys_clk_en(o_sys_clk_en),
  .o_periph_clk_en(o_periph_clk_en), .o_in_idle(o_in_idle), .o_in_sleep(o_in_sleep),
  .o_resume_next(o_resume_next), .o_take_exception(o_take_exception),
  .o_wdt_reset(o_wdt_reset));
`default_nettype wire

/* test/tb_watchdog_and_power_save_control.sv */
/*
  Self-checking bench for the watchdog and power-save controller.
  Assumes wpsc_partner supplies reset and RC clock; checker is bound apart.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_watchdog_and_power_save_control;
  import wpsc_pkg::*;
  typedef struct packed
  {logic idle; logic [2:0] pr; logic [2:0] cp; logic td; logic ex;} wpsc_row_t;
  logic clk, bench_rst, rst, por, psel, pen, pwr, wclr, csw, busy, tdis, low_power_rc_oscillator, perr;
  logic pready, pslverr, cpu_en, sys_en, in_idle, in_sleep, resume, exc, wdt_rst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [2:0] cprio;
  logic [PERIPH_N-1:0] stop_in_idle, pclk;
  wpsc_power_save_instruction_t power_save_instruction;
  wpsc_irq_t irq;
  wpsc_wdt_cfg_t cfg;
  wpsc_row_t rows [4] = '{'{1'b1, 3'h3, 3'h3, 1'b0, 1'b0}, '{1'b1, 3'h5, 3'h2, 1'b0, 1'b1},
    '{1'b0, 3'h4, 3'h3, 1'b1, 1'b1}, '{1'b0, 3'h1, 3'h4, 1'b1, 1'b0}};
  logic [15:0] wcfg [4] = '{16'h0350, 16'h0342, 16'h0341, 16'h0340};
  int wper [4] = '{512, 512, 256, 128};
  int win_start [4] = '{8, 16, 20, 24};
  int num_errors = 0;
  int checked = 0;
  int wn, cnt;
  wpsc_partner part_u (.i_mclk(clk), .i_bench_rst(bench_rst), .i_wdt_rst(wdt_rst),
    .o_rst(rst), .o_low_power_rc_oscillator(low_power_rc_oscillator));
  wpsc_top dut_u (.i_mclk(clk), .i_rst(rst), .i_por_rst(por), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_power_save_instruction(power_save_instruction),
    .i_irq(irq), .i_cpu_prio(cprio), .i_timed_irq_disable(tdis), .i_wdt_clear(wclr),
    .i_clk_switch_done(csw), .i_self_prog_busy(busy), .i_low_power_rc_oscillator_clk(low_power_rc_oscillator),
    .i_wdt_cfg(cfg), .i_stop_in_idle(stop_in_idle), .o_cpu_clk_en(cpu_en),
    .o_sys_clk_en(sys_en), .o_periph_clk_en(pclk), .o_in_idle(in_idle),
    .o_in_sleep(in_sleep), .o_resume_next(resume), .o_take_exception(exc),
    .o_wdt_reset(wdt_rst));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100us;
    num_errors++;
    $display("FAIL %0t run hung", $time);
    close_out();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Request held up to the edge that samples ready; answer taken and released there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    chk(pready, 1, "no ready");
    {rq, perr} = {prdata, pslverr};
    {psel, pen} <= 2'b00;
  endtask
  task automatic wait_sig(input logic w, input int lim);
    wn = 0;
    do
    begin
      @(negedge clk);
      wn++;
    end
    while ((w ? wdt_rst : resume | exc) !== 1'b1 && wn < lim);
    chk(w ? wdt_rst : resume | exc, 1, "event missing");
  endtask
  task automatic clr(input logic sw);
    @(posedge clk);
    {csw, wclr} <= {sw, !sw};
    @(posedge clk);
    {csw, wclr} <= 2'b00;
  endtask
  task automatic wait_rst();
    tick(2);
    while (rst !== 1'b0)
      @(posedge clk);
    tick(2);
  endtask
  initial
  begin
    {psel, pen, pwr, wclr, csw, busy, tdis, bench_rst, por} = 9'h003;
    {paddr, pwdata, cprio, power_save_instruction, irq} = '0;
    cfg = 16'h0340;
    stop_in_idle = 16'h000F;
    tick(16);
    {bench_rst, por} <= 2'b00;
    apb(1'b0, ADDR_CLK_DIV);
    chk(rq, 32'h0, "doze reset");
    apb(1'b0, ADDR_MOD_DIS);
    chk({rq[15:0], pclk}, 32'h0000FFFF, "disable reset");
    apb(1'b0, 12'h010);
    chk({rq[30:0], perr}, 32'h1, "unmapped");
    apb(1'b1, ADDR_MOD_DIS, 32'h00F0);
    tick(2);
    @(negedge clk);
    chk(pclk, 32'hFF0F, "module off");
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, ADDR_CLK_DIV, 32'h800 | (k << 12));
      tick(130);
      cnt = 0;
      repeat (256)
      begin
        @(negedge clk);
        cnt += int'(cpu_en === 1'b1);
      end
      chk(cnt, 256 >> k, "doze rate");
      chk(sys_en, 1, "system rate");
    end
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, ADDR_CLK_DIV, (j == 1) ? 32'h3800 : 32'hB800);
      {tdis, irq} <= {j == 2, 1'b1, 3'h1};
      tick(4);
      {tdis, irq} <= '0;
      apb(1'b0, ADDR_CLK_DIV);
      chk(rq[11], j != 0, "doze after irq");
    end
    apb(1'b1, ADDR_CLK_DIV, 32'h0);
    $display("test doze done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      {cprio, tdis, power_save_instruction} <= {rows[i].cp, rows[i].td, 1'b1, rows[i].idle};
      @(posedge clk);
      power_save_instruction <= '0;
      @(negedge clk);
      chk({in_idle, in_sleep, cpu_en}, {rows[i].idle, !rows[i].idle, 1'b0}, "enter");
      if (rows[i].idle)
        chk(pclk, 32'hFF00, "stop in idle");
      @(posedge clk);
      irq <= {1'b1, rows[i].pr};
      wait_sig(1'b0, 12);
      chk(wn <= 9, 1, "wake delay");
      chk(exc, rows[i].ex, "exception choice");
      @(posedge clk);
      irq <= '0;
      apb(1'b0, ADDR_RESET_CTRL);
      chk(rq[3:2], {!rows[i].idle, rows[i].idle}, "mode flag");
      apb(1'b1, ADDR_RESET_CTRL, 32'h0);
    end
    tdis <= 1'b0;
    $display("test wake done");
    apb(1'b1, ADDR_RESET_CTRL, 32'h20);
    for (int i = 0; i < 4; i++)
    begin
      {cfg, power_save_instruction} <= {wcfg[i], 2'b10};
      @(posedge clk);
      power_save_instruction <= '0;
      wait_sig(1'b0, 600);
      chk(wn >= wper[i] - 8 && wn <= wper[i] + 12, 1, "period");
      chk({exc, resume}, 1, "wdt wake");
      apb(1'b0, ADDR_RESET_CTRL);
      chk(rq[4], 1, "wdt flag");
      apb(1'b1, ADDR_RESET_CTRL, 32'h20);
      clr(1'b0);
    end
    for (int j = 0; j < 3; j++)
    begin
      tick(80);
      clr(j == 1);
    end
    chk(wdt_rst, 0, "cleared in time");
    wait_sig(1'b1, 200);
    chk(wn >= 120 && wn <= 140, 1, "awake timeout");
    wait_rst();
    apb(1'b0, ADDR_RESET_CTRL);
    chk(rq[5:4], 1, "soft off flag on");
    for (int c = 0; c < 4; c++)
    begin
      cfg <= {6'h0, 2'(c), 8'h00};
      apb(1'b1, ADDR_RESET_CTRL, 32'h20);
      tick(4 * win_start[c] - 12);
      clr(1'b0);
      wait_sig(1'b1, 8);
      wait_rst();
    end
    apb(1'b1, ADDR_RESET_CTRL, 32'h20);
    // Window 25%: clear lands near RC edge 26 of 32, inside the allowed fraction
    tick(104);
    clr(1'b0);
    tick(8);
    chk(wdt_rst, 0, "clear in window");
    apb(1'b1, ADDR_RESET_CTRL, 32'h0);
    {cfg, busy} <= {16'h0340, 1'b1};
    apb(1'b1, ADDR_RESET_CTRL, 32'h20);
    tick(200);
    chk(wdt_rst, 0, "held while busy");
    busy <= 1'b0;
    wait_sig(1'b1, 4);
    wait_rst();
    $display("test watchdog done");
    power_save_instruction <= 2'b10;
    @(posedge clk);
    {power_save_instruction, bench_rst} <= 3'b001;
    tick(2);
    bench_rst <= 1'b0;
    tick(2);
    @(negedge clk);
    chk({in_sleep, cpu_en}, 1, "reset wake");
    @(posedge clk);
    cfg <= 16'h03C0;
    wait_sig(1'b1, 200);
    $display("test reset and fuse done");
    close_out();
  end
endmodule
`default_nettype wire
